/* File: ftc_top.sv */
// Tune command port: serial or parallel tune word intake, tune status handshake and registers.
//
// Functional notes
// - Band bits 9:8 pick low, mid or top band; pattern one-one is rejected.
// - After reset the tune status output is driven low, meaning idle.
// - Command start (strobe falling) raises tune status once ready for data.
// - Status returns low after a complete command has been processed.
// - Tune status is a push-pull output, driven in both states.
// - Tune word: bits 15:10 zero, band in 9:8, step index in 7:0.
// - Parallel: first strobe rise latches high byte, second latches low byte.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module ftc_top #(
	parameter int PROC_CYCLES = 16
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic interface_select_i,
	input wire logic load_strobe_n_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic [ftc_pkg::BYTE_W-1:0] par_data_i,
	output logic tune_status_o,
	output ftc_pkg::ftc_band_t band_o,
	output logic [ftc_pkg::FREQ_W-1:0] freq_step_index_o,
	output logic tune_load_o,
	output logic irq_o,
	input wire logic [ftc_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [ftc_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [ftc_pkg::DATA_W-1:0] reg_rdata_o
);

	localparam int SYNC_W = 4 + ftc_pkg::BYTE_W;
	localparam logic [ftc_pkg::CNT_W-1:0] PROC_LAST = ftc_pkg::CNT_W'(PROC_CYCLES - 1);

	// A command is accepted when the pad is zero and the band is a supported one.
	function automatic logic word_ok(input ftc_pkg::ftc_word_t w);
		word_ok = (w.pad == ftc_pkg::PAD_ZERO) && (w.band != ftc_pkg::FTC_BAD_BAND);
	endfunction

	logic [SYNC_W-1:0] sync_bus;
	logic strap_s;
	logic stb_s;
	logic sck_s;
	logic mosi_s;
	logic [ftc_pkg::BYTE_W-1:0] data_s;
	logic stb_prev_q;
	logic sck_prev_q;
	logic stb_fall;
	logic stb_rise;
	logic sck_rise;
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	logic serial_mode_q;
	ftc_pkg::ftc_state_t state_q;
	logic [ftc_pkg::CNT_W-1:0] cnt_q;
	logic byte_cnt_q;
	logic [ftc_pkg::BYTE_W-1:0] msb_q;
	ftc_pkg::ftc_word_t cmd_q;
	logic status_q;
	logic [ftc_pkg::LOW_CNT_W-1:0] low_cnt_q;
	logic long_low;
	logic [ftc_pkg::WORD_W-1:0] shift_word;
	logic [4:0] shift_count;
	logic shift_clear;
	logic shift_en;
	ftc_pkg::ftc_band_t band_q;
	logic [ftc_pkg::FREQ_W-1:0] freq_q;
	logic load_q;
	logic [ftc_pkg::EV_W-1:0] ev;
	logic [ftc_pkg::EV_W-1:0] int_stat_q;
	logic [ftc_pkg::EV_W-1:0] int_en_q;
	logic [7:0] ready_dly_q;
	logic [ftc_pkg::DATA_W-1:0] rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection.

	// Reset levels match each pin's idle level, so no false edge follows reset.
	ftc_sync #(
		.WIDTH(SYNC_W),
		.RST_VAL({1'b1, 1'b1, 1'b0, 1'b0, {ftc_pkg::BYTE_W{1'b0}}})
	) u_sync (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.async_i({interface_select_i, load_strobe_n_i, sck_i, mosi_i, par_data_i}),
		.sync_o(sync_bus)
	);

	// Synchronised views of the pins; the strap idles high so a floating pin reads serial.
	assign {strap_s, stb_s, sck_s, mosi_s, data_s} = sync_bus;

	// Previous levels for edge detection, taken from the second stage only.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stb_prev_q <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			stb_prev_q <= stb_s;
			sck_prev_q <= sck_s;
		end
	end

	assign stb_fall = stb_prev_q & ~stb_s;
	assign stb_rise = ~stb_prev_q & stb_s;
	assign sck_rise = ~sck_prev_q & sck_s;

	////////////////////////////////////////////////////////////////////////////////
	// Interface strap, caught once after the synchroniser has filled.

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
			serial_mode_q <= 1'b1;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == ftc_pkg::STRAP_WAIT) begin
				serial_mode_q <= strap_s;
				strap_done_q <= 1'b1;
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial intake and strobe low-time measurement.

	assign shift_clear = serial_mode_q & stb_fall & state_q[0];
	assign shift_en = serial_mode_q & ~stb_s & sck_rise & state_q[2];

	ftc_shift #(
		.WIDTH(ftc_pkg::WORD_W)
	) u_shift (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.clear_i(shift_clear),
		.shift_i(shift_en),
		.bit_i(mosi_s),
		.word_o(shift_word),
		.count_o(shift_count)
	);

	// Counts how long the strobe has been low; saturates so it never wraps back short.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_cnt_q <= '0;
		end else if (stb_s) begin
			low_cnt_q <= '0;
		end else if (low_cnt_q != '1) begin
			low_cnt_q <= low_cnt_q + 8'h01;
		end
	end

	assign long_low = (low_cnt_q >= ftc_pkg::RECOV_LIMIT);

	////////////////////////////////////////////////////////////////////////////////
	// Command state machine and tune status.

	// The wake delay stands in for the setup time the controller may wait instead of polling.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ftc_pkg::ST_IDLE;
			cnt_q <= '0;
			byte_cnt_q <= 1'b0;
			msb_q <= '0;
			cmd_q <= '0;
			status_q <= 1'b0;
		end else begin
			case (state_q)
				ftc_pkg::ST_IDLE: begin
					if (strap_done_q && stb_fall) begin
						state_q <= ftc_pkg::ST_WAKE;
						cnt_q <= '0;
						byte_cnt_q <= 1'b0;
					end
				end
				ftc_pkg::ST_WAKE: begin
					if (serial_mode_q && stb_rise) begin
						state_q <= ftc_pkg::ST_IDLE;
					end else if (cnt_q >= ftc_pkg::CNT_W'(ready_dly_q)) begin
						state_q <= ftc_pkg::ST_RECV;
						status_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				ftc_pkg::ST_RECV: begin
					if (stb_rise) begin
						if (serial_mode_q) begin
							if (shift_count == ftc_pkg::SER_BITS) begin
								cmd_q <= ftc_pkg::ftc_word_t'(shift_word);
								state_q <= ftc_pkg::ST_PROC;
								cnt_q <= '0;
							end else begin
								// A short serial frame is dropped and the port goes idle.
								state_q <= ftc_pkg::ST_IDLE;
								status_q <= 1'b0;
							end
						end else if (byte_cnt_q && long_low) begin
							state_q <= ftc_pkg::ST_IDLE;
							status_q <= 1'b0;
						end else if (!byte_cnt_q) begin
							msb_q <= data_s;
							byte_cnt_q <= 1'b1;
						end else begin
							cmd_q <= ftc_pkg::ftc_word_t'({msb_q, data_s});
							state_q <= ftc_pkg::ST_PROC;
							cnt_q <= '0;
						end
					end
				end
				ftc_pkg::ST_PROC: begin
					if (cnt_q >= PROC_LAST) begin
						state_q <= ftc_pkg::ST_IDLE;
						status_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				default: begin
					state_q <= ftc_pkg::ST_IDLE;
					status_q <= 1'b0;
				end
			endcase
		end
	end

	assign tune_status_o = status_q;

	////////////////////////////////////////////////////////////////////////////////
	// Applying the tune word.

	// The band and step outputs keep the last good word; a rejected word leaves them alone.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			band_q <= ftc_pkg::FTC_LOW_BAND;
			freq_q <= '0;
			load_q <= 1'b0;
		end else begin
			load_q <= 1'b0;
			if (state_q[3] && cnt_q >= PROC_LAST && word_ok(cmd_q)) begin
				band_q <= cmd_q.band;
				freq_q <= cmd_q.freq_step_index;
				load_q <= 1'b1;
			end
		end
	end

	assign band_o = band_q;
	assign freq_step_index_o = freq_q;
	assign tune_load_o = load_q;

	// One-cycle events feeding the sticky status bits.
	always_comb begin
		ev = '0;
		ev[ftc_pkg::EV_DONE] = state_q[3] && (cnt_q >= PROC_LAST) && word_ok(cmd_q);
		ev[ftc_pkg::EV_INVALID] = state_q[3] && (cnt_q >= PROC_LAST) && !word_ok(cmd_q);
		ev[ftc_pkg::EV_RECOV] = state_q[2] && stb_rise && !serial_mode_q && byte_cnt_q && long_low;
		ev[ftc_pkg::EV_ABORT] = serial_mode_q && stb_rise && (state_q[1] ||
			(state_q[2] && shift_count != ftc_pkg::SER_BITS));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port and interrupt.

	// Software settings; the wake delay is counted in core clock cycles.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			int_en_q <= '0;
			ready_dly_q <= ftc_pkg::READY_DLY_RST;
		end else if (reg_we_i) begin
			if (reg_addr_i == ftc_pkg::OFS_INT_EN) begin
				int_en_q <= reg_wdata_i[ftc_pkg::EV_W-1:0];
			end
			if (reg_addr_i == ftc_pkg::OFS_READY_DLY) begin
				ready_dly_q <= reg_wdata_i[7:0];
			end
		end
	end

	// Sticky events; an event in the same cycle as its clear is kept.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			int_stat_q <= '0;
		end else if (reg_we_i && reg_addr_i == ftc_pkg::OFS_INT_CLR) begin
			int_stat_q <= (int_stat_q & ~reg_wdata_i[ftc_pkg::EV_W-1:0]) | ev;
		end else begin
			int_stat_q <= int_stat_q | ev;
		end
	end

	assign irq_o = |(int_stat_q & int_en_q);

	// Read data stands for exactly one cycle after the read strobe; unmapped reads give zero.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= '0;
		end else if (reg_re_i) begin
			case (reg_addr_i)
				ftc_pkg::OFS_STATUS: rdata_q <= {26'h0000000, state_q, serial_mode_q, status_q};
				ftc_pkg::OFS_TUNE_WORD: rdata_q <= {16'h0000, cmd_q};
				ftc_pkg::OFS_INT_STAT: rdata_q <= {28'h0000000, int_stat_q};
				ftc_pkg::OFS_INT_EN: rdata_q <= {28'h0000000, int_en_q};
				ftc_pkg::OFS_READY_DLY: rdata_q <= {24'h000000, ready_dly_q};
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata_o = rdata_q;

endmodule

/* File: ftc_pkg.sv */
// Shared constants, types and register map of the filter tune command port.
package ftc_pkg;

	// Tune word layout.
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int BAND_W = 2;
	localparam int FREQ_W = 8;
	localparam int PAD_W = 6;

	typedef enum logic [1:0] {
		FTC_LOW_BAND = 2'h0,
		FTC_MID_BAND = 2'h1,
		FTC_TOP_BAND = 2'h2,
		FTC_BAD_BAND = 2'h3
	} ftc_band_t;

	typedef struct packed {
		logic [PAD_W-1:0] pad;
		ftc_band_t band;
		logic [FREQ_W-1:0] freq_step_index;
	} ftc_word_t;

	localparam logic [PAD_W-1:0] PAD_ZERO = 6'h00;

	// Command state machine, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAKE = 4'h2,
		ST_RECV = 4'h4,
		ST_PROC = 4'h8
	} ftc_state_t;

	// Timing.
	localparam int CLK_PERIOD_NS = 4;
	localparam int RECOV_LOW_NS = 300;
	localparam int RECOV_CYCLES = (RECOV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOW_CNT_W = 8;
	localparam logic [LOW_CNT_W-1:0] RECOV_LIMIT = LOW_CNT_W'(RECOV_CYCLES);
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam int CNT_W = 16;
	localparam logic [4:0] SER_BITS = 5'h10;

	// Register map, byte addresses.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TUNE_WORD = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_INT_CLR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_READY_DLY = 8'h14;
	localparam logic [7:0] READY_DLY_RST = 8'h04;

	// Interrupt event bits.
	localparam int EV_W = 4;
	localparam int EV_DONE = 0;
	localparam int EV_INVALID = 1;
	localparam int EV_RECOV = 2;
	localparam int EV_ABORT = 3;

endpackage

/* File: ftc_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ns
module ftc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

/* File: ftc_shift.sv */
// Serial receive shift register with a saturating bit counter.
`timescale 1ns/1ns
module ftc_shift #(
	parameter int WIDTH = 16
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic clear_i,
	input wire logic shift_i,
	input wire logic bit_i,
	output logic [WIDTH-1:0] word_o,
	output logic [4:0] count_o
);

	logic [WIDTH-1:0] word_q;
	logic [4:0] count_q;

	// Bits enter at the bottom, so the first bit sent ends up most significant.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			word_q <= '0;
			count_q <= 5'h00;
		end else if (clear_i) begin
			word_q <= '0;
			count_q <= 5'h00;
		end else if (shift_i) begin
			word_q <= {word_q[WIDTH-2:0], bit_i};
			// Extra bits still shift in, so the word holds the last WIDTH bits; the count stops at the word length.
			if (count_q != 5'(WIDTH)) begin
				count_q <= count_q + 5'h01;
			end
		end
	end

	assign word_o = word_q;
	assign count_o = count_q;

endmodule

/* File: ftc_monitor.sv */
// Concurrent checks on the tune command port pins and register read path.
`timescale 1ns/1ns
module ftc_top_monitor #(
	parameter int PROC_CYCLES = 16
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic load_strobe_n_i,
	input wire logic tune_status_o,
	input wire ftc_pkg::ftc_band_t band_o,
	input wire logic [ftc_pkg::FREQ_W-1:0] freq_step_index_o,
	input wire logic tune_load_o,
	input wire logic reg_re_i,
	input wire logic [ftc_pkg::DATA_W-1:0] reg_rdata_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////
	// A strobe fall while idle; status must wait for the synchroniser.
	sequence s_wake;
		$fell(load_strobe_n_i) && !tune_status_o;
	endsequence
	sequence s_ready;
		!tune_status_o [*3] ##[1:300] tune_status_o;
	endsequence
	property p_wake;
		s_wake |-> s_ready;
	endproperty
	property p_reset_idle;
		!$past(resetn_i) |-> !tune_status_o && !tune_load_o;
	endproperty
	property p_load_drop;
		tune_load_o |-> $fell(tune_status_o);
	endproperty
	property p_load_pulse;
		tune_load_o |=> !tune_load_o;
	endproperty
	property p_band_ok;
		band_o != ftc_pkg::FTC_BAD_BAND;
	endproperty
	property p_out_change;
		$changed(band_o) || $changed(freq_step_index_o) |-> tune_load_o;
	endproperty
	property p_drop_after_rise;
		$fell(tune_status_o) |-> $past(load_strobe_n_i, 2);
	endproperty
	property p_rdata_zero;
		!reg_re_i |=> reg_rdata_o == '0;
	endproperty
	a_wake: assert property (p_wake) else $error("status did not rise after strobe fall");
	a_reset_idle: assert property (p_reset_idle) else $error("status not idle after reset");
	a_load_drop: assert property (p_load_drop) else $error("load pulse without status drop");
	a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
	a_band_ok: assert property (p_band_ok) else $error("unsupported band applied");
	a_out_change: assert property (p_out_change) else $error("outputs changed without load");
	a_drop_after_rise: assert property (p_drop_after_rise) else $error("status fell with strobe low");
	a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside read slot");
endmodule
bind ftc_top ftc_top_monitor #(.PROC_CYCLES(PROC_CYCLES)) i_mon (
	.core_clk_i(core_clk_i),
	.resetn_i(resetn_i),
	.load_strobe_n_i(load_strobe_n_i),
	.tune_status_o(tune_status_o),
	.band_o(band_o),
	.freq_step_index_o(freq_step_index_o),
	.tune_load_o(tune_load_o),
	.reg_re_i(reg_re_i),
	.reg_rdata_o(reg_rdata_o)
);

/* File: ftc_ctl_model.sv */
// Behavioural tune controller driving the strobe, serial and parallel pins.
`timescale 1ns/1ns
module ftc_ctl_model (
	input wire logic core_clk_i,
	input wire logic tune_status_i,
	output logic load_strobe_n_o,
	output logic sck_o,
	output logic mosi_o,
	output logic [7:0] par_data_o,
	output logic fault_o
);
	// Idle pins; the link clock stands still between frames.
	initial begin
		load_strobe_n_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b0;
		par_data_o = 8'h00;
		fault_o = 1'b0;
	end
	task automatic wait_ready();
		int k;
		k = 0;
		while (tune_status_i !== 1'b1 && k < 400) begin
			@(posedge core_clk_i);
			k++;
		end
		if (tune_status_i !== 1'b1)
			fault_o = 1'b1;
	endtask
	task automatic par_send(input logic [15:0] w, input bit two);
		load_strobe_n_o <= 1'b0;
		wait_ready();
		par_data_o <= w[15:8];
		repeat (4) @(posedge core_clk_i);
		load_strobe_n_o <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		if (two) begin
			load_strobe_n_o <= 1'b0;
			par_data_o <= w[7:0];
			repeat (4) @(posedge core_clk_i);
			load_strobe_n_o <= 1'b1;
			repeat (8) @(posedge core_clk_i);
		end
		par_data_o <= ~par_data_o; // A released bus must not show the last byte.
	endtask
	task automatic recover();
		load_strobe_n_o <= 1'b0;
		repeat (80) @(posedge core_clk_i);
		load_strobe_n_o <= 1'b1;
		repeat (8) @(posedge core_clk_i);
	endtask
	task automatic ser_send(input logic [15:0] w, input int nbits);
		load_strobe_n_o <= 1'b0;
		wait_ready();
		for (int i = 15; i > 15 - nbits; i--) begin
			mosi_o <= w[i];
			repeat (8) @(posedge core_clk_i);
			sck_o <= 1'b1;
			repeat (8) @(posedge core_clk_i);
			sck_o <= 1'b0;
		end
		repeat (4) @(posedge core_clk_i);
		load_strobe_n_o <= 1'b1;
		mosi_o <= ~mosi_o;
	endtask
endmodule

/* File: filter_tune_command_port_tb_top.sv */
// Self-checking bench for the filter tune command port.
`timescale 1ns/1ns
module filter_tune_command_port_tb_top;
	logic core_clk_i;
	logic resetn_i;
	logic interface_select_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic reg_we_i;
	logic reg_re_i;
	logic strobe_n;
	logic sck;
	logic mosi;
	logic [7:0] pdata;
	logic fault;
	logic tune_status_o;
	ftc_pkg::ftc_band_t band_o;
	logic [7:0] freq_o;
	logic irq_o;
	logic [31:0] rdata;
	logic tune_load;
	int loads = 0;
	logic [15:0] pw [3] = '{16'h0048, 16'h01f9, 16'h028b};
	logic [15:0] sw [3] = '{16'h00fa, 16'h0143, 16'h0200};
	int error_cnt = 0;
	int num_checks = 0;
	// Free-running core clock.
	always #2 core_clk_i = ~core_clk_i;
	ftc_top #(.PROC_CYCLES(2)) i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.interface_select_i(interface_select_i), .load_strobe_n_i(strobe_n), .sck_i(sck),
		.mosi_i(mosi), .par_data_i(pdata), .tune_status_o(tune_status_o), .band_o(band_o),
		.freq_step_index_o(freq_o), .tune_load_o(tune_load), .irq_o(irq_o), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(rdata));
	// Counts applied tune words, one per load pulse.
	always @(posedge core_clk_i)
		if (tune_load === 1'b1)
			loads <= loads + 1;
	ftc_ctl_model i_ctl (.core_clk_i(core_clk_i), .tune_status_i(tune_status_o),
		.load_strobe_n_o(strobe_n), .sck_o(sck), .mosi_o(mosi), .par_data_o(pdata), .fault_o(fault));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge core_clk_i);
		reg_we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge core_clk_i);
		reg_re_i <= 1'b0;
		// Read data stand only in this cycle, so they are looked at mid-cycle.
		@(negedge core_clk_i);
		chk($sformatf("reg %h", a), e, rdata);
		@(posedge core_clk_i);
	endtask
	task automatic boot(input logic sel);
		@(posedge core_clk_i);
		resetn_i <= 1'b0;
		interface_select_i <= sel;
		repeat (5) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		repeat (10) @(posedge core_clk_i);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (tune_status_o !== 1'b0 && k < 400) begin
			@(posedge core_clk_i);
			k++;
		end
		if (tune_status_o !== 1'b0 || fault !== 1'b0) begin
			error_cnt++;
			$display("unexpected idle wait: expected 0, seen %b", tune_status_o);
			wrap_up();
		end
	endtask
	task automatic chk_out(input logic [15:0] w);
		chk("band", 32'(w[9:8]), 32'(band_o));
		chk("step", 32'(w[7:0]), 32'(freq_o));
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("status", 32'h0, 32'(tune_status_o));
		chk_out(16'h0000);
		rd(ftc_pkg::OFS_READY_DLY, 32'h4);
		wr(ftc_pkg::OFS_READY_DLY, 32'h6);
		rd(ftc_pkg::OFS_READY_DLY, 32'h6);
		rd(8'h40, 32'h0);
		interface_select_i <= 1'b1;
		rd(ftc_pkg::OFS_STATUS, 32'h4);
		$display("reset test done");
	endtask
	task automatic t_par();
		wr(ftc_pkg::OFS_INT_EN, 32'h1);
		rd(ftc_pkg::OFS_INT_EN, 32'h1);
		foreach (pw[i]) begin
			i_ctl.par_send(pw[i], 1'b1);
			wait_idle();
			chk_out(pw[i]);
			rd(ftc_pkg::OFS_TUNE_WORD, 32'(pw[i]));
			chk("irq", 32'h1, 32'(irq_o));
			wr(ftc_pkg::OFS_INT_CLR, 32'hf);
			rd(ftc_pkg::OFS_INT_STAT, 32'h0);
			chk("irq", 32'h0, 32'(irq_o));
		end
		chk("loads", 32'h3, 32'(loads));
		$display("parallel test done");
	endtask
	task automatic t_inv();
		i_ctl.par_send(16'h0312, 1'b1);
		wait_idle();
		chk_out(16'h028b);
		i_ctl.par_send(16'h0412, 1'b1);
		wait_idle();
		chk_out(16'h028b);
		rd(ftc_pkg::OFS_INT_STAT, 32'h2);
		chk("irq", 32'h0, 32'(irq_o));
		wr(ftc_pkg::OFS_INT_CLR, 32'hf);
		chk("loads", 32'h3, 32'(loads));
		$display("invalid test done");
	endtask
	task automatic t_rec();
		i_ctl.par_send(16'h0150, 1'b0);
		chk("status", 32'h1, 32'(tune_status_o));
		i_ctl.recover();
		wait_idle();
		rd(ftc_pkg::OFS_INT_STAT, 32'h4);
		chk_out(16'h028b);
		wr(ftc_pkg::OFS_INT_CLR, 32'hf);
		i_ctl.par_send(16'h0100, 1'b1);
		wait_idle();
		chk_out(16'h0100);
		chk("loads", 32'h4, 32'(loads));
		$display("recovery test done");
	endtask
	task automatic t_ser();
		boot(1'b1);
		rd(ftc_pkg::OFS_STATUS, 32'h6);
		foreach (sw[i]) begin
			i_ctl.ser_send(sw[i], 16);
			wait_idle();
			chk_out(sw[i]);
			rd(ftc_pkg::OFS_TUNE_WORD, 32'(sw[i]));
		end
		// A cut frame of eight bits must end the command without applying it.
		wr(ftc_pkg::OFS_INT_CLR, 32'hf);
		i_ctl.ser_send(16'h0155, 8);
		wait_idle();
		chk_out(16'h0200);
		rd(ftc_pkg::OFS_INT_STAT, 32'h8);
		$display("serial test done");
	endtask
	// Main sequence: parallel boot first, then a serial boot.
	initial begin
		core_clk_i = 1'b0;
		resetn_i = 1'b0;
		interface_select_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		boot(1'b0);
		t_reset();
		t_par();
		t_inv();
		t_rec();
		t_ser();
		wrap_up();
	end
endmodule
